// ---- rtl/cic_upconvert_defines.vh ----
`ifndef CIC_UPCONVERT_DEFINES_VH
`define CIC_UPCONVERT_DEFINES_VH

// global control byte
`define CTRL_REG_ADDR        5'h06
`define CTRL_INV_CIC_BYP_BIT 0
`define CTRL_INV_SINC_BYP_BIT 1

// per-profile layout: base + 0 ctrl, +1..+4 freq word (lsb first), +5 scale
`define PROF0_BASE           5'h07
`define PROF_STRIDE          5'd6
`define PROF_LAST_ADDR       5'h1e
`define PROF_FREQ_WORD_OFS   5'h01
`define PROF_SCALE_OFS       5'h05
`define PROF1_FREQ_WORD_ADDR 5'h08

// profile ctrl byte fields
`define PCTRL_RATIO_MSB      5
`define PCTRL_RATIO_LSB      0
`define PCTRL_CIC_BYP_BIT    6
`define PCTRL_SPEC_INV_BIT   7

// reset values
`define RST_SCALE            8'hb5
`define RST_PCTRL            8'h02
`define RST_OTHER            8'h00
`define SCALE_UNITY          8'h80

// datapath
`define SAMPLE_W             14
`define CIC_ORDER            5
`define CIC_ACC_W            44
`define CARRIER_QUARTER      32'h40000000

`endif

// ---- rtl/cic_interp.v ----
`timescale 1ns/1ps
`include "cic_upconvert_defines.vh"

module cic_interp (
    input  wire                 mclk,
    input  wire                 resetn,
    input  wire [5:0]           ratio,
    input  wire                 bypass,
    input  wire signed [13:0]   in_data,
    output wire                 take,
    output reg  signed [13:0]   out_data
);
    reg         [5:0]               phase_cnt;
    reg  signed [`CIC_ACC_W-1:0]    comb_dly [0:`CIC_ORDER-1];
    reg  signed [`CIC_ACC_W-1:0]    integ    [0:`CIC_ORDER-1];
    reg  signed [`CIC_ACC_W-1:0]    comb_val [0:`CIC_ORDER];
    reg  signed [`CIC_ACC_W-1:0]    shifted;
    wire        [5:0]               eff_ratio;
    wire        [4:0]               gain_shift;
    integer                         k;

    function [2:0] clog2_6;
        input [5:0] v;
        begin
            if (v > 6'd32)
                clog2_6 = 3'd6;
            else if (v > 6'd16)
                clog2_6 = 3'd5;
            else if (v > 6'd8)
                clog2_6 = 3'd4;
            else if (v > 6'd4)
                clog2_6 = 3'd3;
            else if (v > 6'd2)
                clog2_6 = 3'd2;
            else
                clog2_6 = 3'd1;
        end
    endfunction

    // ratios below two are not legal interpolation rates; treat them as two
    assign eff_ratio  = (ratio < 6'd2) ? 6'd2 : ratio; // [RULE1]
    assign take       = bypass | (phase_cnt == 6'd0);
    // net gain is ratio^4; dividing by the next power of two keeps it <= 1
    assign gain_shift = {clog2_6(eff_ratio), 2'b00};

    always @* begin
        comb_val[0] = {{(`CIC_ACC_W-14){in_data[13]}}, in_data};
        for (k = 0; k < `CIC_ORDER; k = k + 1) begin
            comb_val[k+1] = comb_val[k] - comb_dly[k]; // [RULE4]
        end
        shifted = integ[`CIC_ORDER-1] >>> gain_shift;
    end

    always @(posedge mclk) begin
        if (!resetn) begin
            phase_cnt <= 6'd0;
            out_data  <= 14'h0000;
            for (k = 0; k < `CIC_ORDER; k = k + 1) begin
                comb_dly[k] <= {`CIC_ACC_W{1'b0}};
                integ[k]    <= {`CIC_ACC_W{1'b0}};
            end
        end else if (bypass) begin
            // integrator and comb state frozen while bypassed, phase count cleared, standing in for removed power
            phase_cnt <= 6'd0;
            out_data  <= in_data; // [RULE2]
        end else begin
            if (phase_cnt == eff_ratio - 6'd1)
                phase_cnt <= 6'd0;
            else
                phase_cnt <= phase_cnt + 6'd1;
            if (take) begin
                for (k = 0; k < `CIC_ORDER; k = k + 1) begin
                    comb_dly[k] <= comb_val[k];
                end
            end
            // zero-stuffed comb output feeds five integrators at full rate
            integ[0] <= integ[0] +
                        (take ? comb_val[`CIC_ORDER] : {`CIC_ACC_W{1'b0}});
            for (k = 1; k < `CIC_ORDER; k = k + 1) begin
                integ[k] <= integ[k] + integ[k-1]; // [RULE4]
            end
            out_data <= shifted[13:0];
        end
    end
endmodule

// ---- rtl/sine_lookup.v ----
`timescale 1ns/1ps

module sine_lookup (
    input  wire [5:0]           phase,
    output reg  signed [11:0]   value
);
    reg [3:0]  idx;
    reg [11:0] mag;

    // quarter-wave table sampled at bin centres, so no entry is exactly zero
    always @* begin
        idx = phase[4] ? ~phase[3:0] : phase[3:0];
        case (idx)
            4'h0:    mag = 12'h064;
            4'h1:    mag = 12'h12c;
            4'h2:    mag = 12'h1f1;
            4'h3:    mag = 12'h2b2;
            4'h4:    mag = 12'h36b;
            4'h5:    mag = 12'h41c;
            4'h6:    mag = 12'h4c3;
            4'h7:    mag = 12'h55f;
            4'h8:    mag = 12'h5ed;
            4'h9:    mag = 12'h66c;
            4'ha:    mag = 12'h6dc;
            4'hb:    mag = 12'h73a;
            4'hc:    mag = 12'h787;
            4'hd:    mag = 12'h7c2;
            4'he:    mag = 12'h7e9;
            default: mag = 12'h7fd;
        endcase
        value = phase[5] ? (12'h000 - mag) : mag;
    end
endmodule

// ---- rtl/cic_upconvert_datapath.v ----
`timescale 1ns/1ps
`include "cic_upconvert_defines.vh"

// How it works
// RULE1 - The CIC interpolation ratio comes from a six-bit field, any integer from two to sixty-three.
// RULE2 - Each profile can bypass the CIC stage, which then passes samples at unity rate with its state frozen.
// RULE3 - Bypassing the CIC stage also bypasses the inverse-CIC stage regardless of its own bypass bit.
// RULE4 - The CIC stage is fifth order: a length-R moving sum raised to the fifth power at the sample clock.
// RULE5 - Each profile's spectral-invert bit selects I*cos+Q*sin when one and I*cos-Q*sin when zero.
// RULE6 - The modulator multiplies I by cosine and Q by the quarter-cycle-shifted sine and sums the products; the code multiplies Q by the unshifted sine.
// RULE7 - Modulator input and output both run at the internal sample clock, the converter's rate.
// RULE8 - A per-profile 32-bit frequency word is added to a phase accumulator every sample clock.
// RULE9 - Profile one's frequency word sits in byte registers 0x08 to 0x0b, written through the control port.
// RULE10 - The inverse-sinc filter can be bypassed, in which case its taps stop and samples pass unfiltered.
// RULE11 - The inverse-sinc filter loses about 3.5 dB at low frequency to flatten response up to 45% of clock.
// RULE12 - Samples are multiplied by a per-profile 8-bit unsigned scale with an lsb weight of two to the -7.
// RULE13 - The scale value resets to 0xb5, roughly the square root of two.
// RULE14 - A scale of 0x80 bypasses the multiplier and passes samples unchanged.
// RULE15 - A 14-bit sample is delivered to the converter on every sample clock.
// RULE16 - Bit zero of register 0x06 bypasses the inverse-CIC stage and freezes its state.
// RULE17 - The scaled product saturates to the signed 14-bit range instead of wrapping.
module cic_upconvert_datapath (
    input  wire                 mclk,
    input  wire                 resetn,
    input  wire [1:0]           profile_sel,
    input  wire                 reg_we,
    input  wire [4:0]           reg_addr,
    input  wire [7:0]           reg_wdata,
    output reg  [7:0]           reg_rdata,
    input  wire signed [13:0]   i_data,
    input  wire signed [13:0]   q_data,
    input  wire                 iq_valid,
    output wire                 iq_ready,
    output reg  signed [13:0]   dac_data
);
    reg         [7:0]   regs [0:31];
    reg         [1:0]   psel_meta;
    reg         [1:0]   psel;
    reg  signed [13:0]  i_hist1;
    reg  signed [13:0]  i_hist2;
    reg  signed [13:0]  q_hist1;
    reg  signed [13:0]  q_hist2;
    reg         [31:0]  phase_acc;
    reg  signed [13:0]  mod_out;
    reg  signed [13:0]  sinc_tap0;
    reg  signed [13:0]  sinc_tap1;
    reg  signed [13:0]  sinc_tap2;
    reg  signed [13:0]  sinc_out;
    integer             n;

    wire        [4:0]   prof_base;
    wire        [7:0]   pctrl;
    wire        [31:0]  carrier_freq_word;
    wire        [7:0]   scale;
    wire                cic_bypass;
    wire                inv_cic_bypass;
    wire                inv_sinc_bypass;
    wire                take_i;
    wire                take_q;
    wire signed [13:0]  i_in;
    wire signed [13:0]  q_in;
    wire signed [13:0]  i_comp;
    wire signed [13:0]  q_comp;
    wire signed [13:0]  i_up;
    wire signed [13:0]  q_up;
    wire signed [11:0]  sin_val;
    wire signed [11:0]  cos_val;
    wire        [31:0]  cos_phase;
    wire signed [25:0]  i_prod;
    wire signed [25:0]  q_prod;
    wire signed [26:0]  mod_sum;
    wire signed [19:0]  sinc_sum;
    wire signed [22:0]  scaled;

    function [7:0] reset_value;
        input [4:0] a;
        reg   [4:0] rel;
        begin
            reset_value = `RST_OTHER;
            // bytes past the last profile are plain storage and reset to zero
            if (a >= `PROF0_BASE && a <= `PROF_LAST_ADDR) begin
                rel = (a - `PROF0_BASE) % `PROF_STRIDE;
                if (rel == 5'd0)
                    reset_value = `RST_PCTRL;
                else if (rel == `PROF_SCALE_OFS)
                    reset_value = `RST_SCALE; // [RULE13]
            end
        end
    endfunction

    function [13:0] sat14;
        input signed [19:0] v;
        begin
            if (v > 20'sd8191)
                sat14 = 14'h1fff;
            else if (v < -20'sd8192)
                sat14 = 14'h2000;
            else
                sat14 = v[13:0];
        end
    endfunction

    // three-tap peaking compensation: centre plus a small high-pass share
    function [13:0] inv_cic;
        input signed [13:0] x0;
        input signed [13:0] x1;
        input signed [13:0] x2;
        reg   signed [19:0] hp;
        begin
            hp = ({{6{x1[13]}}, x1} <<< 1) - {{6{x0[13]}}, x0}
                 - {{6{x2[13]}}, x2};
            inv_cic = sat14($signed({{6{x1[13]}}, x1}) + (hp >>> 4));
        end
    endfunction

    // register file, byte wide, as written by the serial control port
    always @(posedge mclk) begin
        if (!resetn) begin
            for (n = 0; n < 32; n = n + 1) begin
                regs[n] <= reset_value(n[4:0]);
            end
            reg_rdata <= 8'h00;
        end else begin
            if (reg_we)
                regs[reg_addr] <= reg_wdata; // [RULE9]
            reg_rdata <= regs[reg_addr];
        end
    end

    // profile pins come from outside the clock domain
    always @(posedge mclk) begin
        if (!resetn) begin
            psel_meta <= 2'b00;
            psel      <= 2'b00;
        end else begin
            psel_meta <= profile_sel;
            psel      <= psel_meta;
        end
    end

    assign prof_base = `PROF0_BASE + {1'b0, psel, 2'b00} + {2'b00, psel, 1'b0};
    assign pctrl     = regs[prof_base];
    assign carrier_freq_word = {regs[prof_base + 5'd4],
                                regs[prof_base + 5'd3],
                                regs[prof_base + 5'd2],
                                regs[prof_base + `PROF_FREQ_WORD_OFS]};
    assign scale     = regs[prof_base + `PROF_SCALE_OFS];

    assign cic_bypass      = pctrl[`PCTRL_CIC_BYP_BIT]; // [RULE2]
    assign inv_cic_bypass  = regs[`CTRL_REG_ADDR][`CTRL_INV_CIC_BYP_BIT]
                             | cic_bypass; // [RULE3] [RULE16]
    assign inv_sinc_bypass = regs[`CTRL_REG_ADDR][`CTRL_INV_SINC_BYP_BIT];

    // a missing upstream sample is taken as zero so the output never stalls
    assign iq_ready = take_i;
    assign i_in     = iq_valid ? i_data : 14'h0000;
    assign q_in     = iq_valid ? q_data : 14'h0000;

    // inverse-cic history advances only on taken samples, frozen when bypassed
    always @(posedge mclk) begin
        if (!resetn) begin
            i_hist1 <= 14'h0000;
            i_hist2 <= 14'h0000;
            q_hist1 <= 14'h0000;
            q_hist2 <= 14'h0000;
        end else if (take_i && !inv_cic_bypass) begin // [RULE16]
            i_hist1 <= i_in;
            i_hist2 <= i_hist1;
            q_hist1 <= q_in;
            q_hist2 <= q_hist1;
        end
    end

    // filtered output carries one sample of delay against the bypass path
    assign i_comp = inv_cic_bypass ? i_in : inv_cic(i_in, i_hist1, i_hist2);
    assign q_comp = inv_cic_bypass ? q_in : inv_cic(q_in, q_hist1, q_hist2);

    cic_interp u_cic_i (
        .mclk     (mclk),
        .resetn   (resetn),
        .ratio    (pctrl[`PCTRL_RATIO_MSB:`PCTRL_RATIO_LSB]), // [RULE1]
        .bypass   (cic_bypass),
        .in_data  (i_comp),
        .take     (take_i),
        .out_data (i_up)
    );

    cic_interp u_cic_q (
        .mclk     (mclk),
        .resetn   (resetn),
        .ratio    (pctrl[`PCTRL_RATIO_MSB:`PCTRL_RATIO_LSB]),
        .bypass   (cic_bypass),
        .in_data  (q_comp),
        .take     (take_q),
        .out_data (q_up)
    );

    always @(posedge mclk) begin
        if (!resetn)
            phase_acc <= 32'h00000000;
        else
            phase_acc <= phase_acc + carrier_freq_word; // [RULE8]
    end

    assign cos_phase = phase_acc + `CARRIER_QUARTER; // [RULE6]

    sine_lookup u_sin (
        .phase (phase_acc[31:26]),
        .value (sin_val)
    );

    sine_lookup u_cos (
        .phase (cos_phase[31:26]),
        .value (cos_val)
    );

    assign i_prod  = i_up * cos_val; // [RULE6]
    assign q_prod  = q_up * sin_val;
    assign mod_sum = pctrl[`PCTRL_SPEC_INV_BIT]
                     ? ({i_prod[25], i_prod} + {q_prod[25], q_prod})
                     : ({i_prod[25], i_prod} - {q_prod[25], q_prod}); // [RULE5]

    // new modulated sample every clock at the converter rate
    always @(posedge mclk) begin
        if (!resetn)
            mod_out <= 14'h0000;
        else
            mod_out <= sat14($signed(mod_sum[26:7]) >>> 4); // [RULE7]
    end

    // taps -1, 13, -1 over 16: dc gain 11/16 (about -3.3 dB), rising toward
    // nyquist to offset the converter's hold droop
    assign sinc_sum = ({{6{sinc_tap1[13]}}, sinc_tap1} * 20'sd13)
                      - {{6{sinc_tap0[13]}}, sinc_tap0}
                      - {{6{sinc_tap2[13]}}, sinc_tap2}; // [RULE11]

    always @(posedge mclk) begin
        if (!resetn) begin
            sinc_tap0 <= 14'h0000;
            sinc_tap1 <= 14'h0000;
            sinc_tap2 <= 14'h0000;
            sinc_out  <= 14'h0000;
        end else if (inv_sinc_bypass) begin
            sinc_out <= mod_out; // [RULE10]
        end else begin
            sinc_tap0 <= mod_out;
            sinc_tap1 <= sinc_tap0;
            sinc_tap2 <= sinc_tap1;
            sinc_out  <= sat14(sinc_sum >>> 4); // [RULE11]
        end
    end

    assign scaled = sinc_out * $signed({1'b0, scale}); // [RULE12]

    always @(posedge mclk) begin
        if (!resetn)
            dac_data <= 14'h0000;
        else if (scale == `SCALE_UNITY)
            dac_data <= sinc_out; // [RULE14]
        else
            dac_data <= sat14($signed(scaled[22:3]) >>> 4); // [RULE15] [RULE17]
    end
endmodule

// ---- verif/cic_upconvert_properties.sv ----
`timescale 1ns/1ps
module cic_upconvert_properties (
    input wire               mclk,
    input wire               resetn,
    input wire [1:0]         profile_sel,
    input wire               reg_we,
    input wire [4:0]         reg_addr,
    input wire [7:0]         reg_wdata,
    input wire [7:0]         reg_rdata,
    input wire signed [13:0] i_data,
    input wire signed [13:0] q_data,
    input wire               iq_valid,
    input wire               iq_ready,
    input wire signed [13:0] dac_data
);
    reg  [7:0] ctrl0;
    reg  [7:0] scale0;
    reg  [7:0] calm;
    reg  [6:0] gap;
    wire       hit = reg_we && (reg_addr == 5'h07 || reg_addr == 5'h0c);
    wire       settled = (calm == 8'hc0);
    wire [5:0] eff = (ctrl0[5:0] < 6'h02) ? 6'h02 : ctrl0[5:0];
    // shadow profile 0 settings; settled leaves room for the odd interval
    always @(posedge mclk) begin
        if (!resetn) begin
            ctrl0 <= 8'h02;
            scale0 <= 8'hb5;
        end else if (reg_we && reg_addr == 5'h07) begin
            ctrl0 <= reg_wdata;
        end else if (reg_we && reg_addr == 5'h0c) begin
            scale0 <= reg_wdata;
        end
    end
    always @(posedge mclk) begin
        if (!resetn || hit || profile_sel != 2'h0) begin
            calm <= 8'h00;
        end else if (!settled) begin
            calm <= calm + 8'h01;
        end
        if (iq_ready) begin
            gap <= 7'h01;
        end else if (gap != 7'h7f) begin
            gap <= gap + 7'h01;
        end
    end
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!resetn);
    sequence wrote_s;
        reg_we ##1 $stable(reg_addr) ##1 1'b1;
    endsequence
    sequence quiet_s;
        !reg_we ##1 $stable(reg_addr) ##1 1'b1;
    endsequence
    out_reset_a: assert property (disable iff (1'b0) !resetn |=>
        dac_data == 14'h0000 && reg_rdata == 8'h00)
        else $error("outputs not cleared in reset");
    ready_reset_a: assert property (disable iff (1'b0)
        !resetn ##1 !resetn |-> iq_ready)
        else $error("sample not taken in reset");
    readback_a: assert property (wrote_s |->
        reg_rdata == $past(reg_wdata, 2))
        else $error("written byte not read back");
    rdata_hold_a: assert property (quiet_s |-> $stable(reg_rdata))
        else $error("byte changed without a write");
    ready_bypass_a: assert property (settled && ctrl0[6] |-> iq_ready)
        else $error("bypassed stage skipped a sample");
    ready_gap_a: assert property (settled && !ctrl0[6] && iq_ready
        |=> !iq_ready)
        else $error("two samples taken back to back");
    ready_period_a: assert property (settled && !ctrl0[6] && iq_ready
        |-> gap == {1'b0, eff})
        else $error("sample spacing differs from ratio");
    scale_zero_a: assert property (settled && scale0 == 8'h00
        |-> dac_data == 14'h0000)
        else $error("zero gain gave nonzero output");
endmodule
bind cic_upconvert_datapath cic_upconvert_properties chk (
    .mclk(mclk), .resetn(resetn), .profile_sel(profile_sel),
    .reg_we(reg_we), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .i_data(i_data), .q_data(q_data),
    .iq_valid(iq_valid), .iq_ready(iq_ready), .dac_data(dac_data)
);

// ---- verif/upstream_hb_model.sv ----
`timescale 1ns/1ps
module upstream_hb_model (
    input  wire               mclk,
    input  wire               iq_ready,
    input  wire signed [13:0] level_i,
    input  wire signed [13:0] level_q,
    input  wire               hold_off,
    output reg  signed [13:0] i_data,
    output reg  signed [13:0] q_data,
    output reg                iq_valid
);
    initial begin
        i_data = 14'h0000;
        q_data = 14'h0000;
        iq_valid = 1'b0;
    end
    // a pair is replaced only once taken; idle slots carry junk, not stale data
    always @(posedge mclk) begin
        if (iq_ready) begin
            iq_valid <= !hold_off;
            i_data <= hold_off ? ~i_data : level_i;
            q_data <= hold_off ? ~q_data : level_q;
        end
    end
endmodule

// ---- verif/tb.sv ----
`timescale 1ns/1ps
module tb;
    reg               mclk = 1'b0;
    reg               resetn = 1'b0;
    reg  [1:0]        profile_sel = 2'h0;
    reg               reg_we = 1'b0;
    reg  [4:0]        reg_addr = 5'h00;
    reg  [7:0]        reg_wdata = 8'h00;
    reg  [13:0]       level_i = 14'h0000;
    reg  [13:0]       level_q = 14'h0000;
    reg               hold_off = 1'b0;
    wire [7:0]        reg_rdata;
    wire [13:0]       i_data;
    wire [13:0]       q_data;
    wire [13:0]       dac_data;
    wire              iq_valid;
    wire              iq_ready;
    integer           err_count = 0;
    integer           samples_checked = 0;
    integer           k;
    integer           n;
    integer           eff;
    integer           nz;
    reg  [7:0]        r;
    reg  [7:0]        mdl [0:31];
    reg signed [13:0] d [0:3];
    reg  [16:0]       seed = 17'h14033;
    always #50 mclk = ~mclk;
    cic_upconvert_datapath uut (
        .mclk(mclk), .resetn(resetn), .profile_sel(profile_sel),
        .reg_we(reg_we), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .i_data(i_data), .q_data(q_data),
        .iq_valid(iq_valid), .iq_ready(iq_ready), .dac_data(dac_data)
    );
    upstream_hb_model up (
        .mclk(mclk), .iq_ready(iq_ready), .level_i(level_i),
        .level_q(level_q), .hold_off(hold_off), .i_data(i_data),
        .q_data(q_data), .iq_valid(iq_valid)
    );
    function [16:0] lfsr(input [16:0] s);
        lfsr = {s[15:0], s[16] ^ s[13]};
    endfunction
    task check(input [13:0] seen, input [13:0] exp, input integer tol);
        integer dv;
        begin
            dv = $signed(seen) - $signed(exp);
            samples_checked = samples_checked + 1;
            if (seen !== exp && (^seen === 1'bx || dv > tol || dv < -tol)) begin
                err_count = err_count + 1;
                $display("Error at %0t: seen %h expected %h", $time, seen, exp);
            end
        end
    endtask
    task idle(input integer c);
        begin
            repeat (c) @(posedge mclk);
            #1;
        end
    endtask
    task wr(input [4:0] a, input [7:0] v);
        begin
            @(posedge mclk);
            reg_we <= 1'b1;
            reg_addr <= a;
            reg_wdata <= v;
            mdl[a] = v;
            @(posedge mclk);
            reg_we <= 1'b0;
        end
    endtask
    task rd(input [4:0] a);
        begin
            @(posedge mclk);
            reg_addr <= a;
            idle(2);
            check({6'h00, reg_rdata}, {6'h00, mdl[a]}, 0);
        end
    endtask
    task out_case(input [13:0] li, input [7:0] sc, input [13:0] exp,
                  input integer tol);
        begin
            @(posedge mclk);
            level_i <= li;
            wr(5'h0c, sc);
            idle(200);
            check(dac_data, exp, tol);
        end
    endtask
    task results;
        begin
            $display("checks %0d mismatches %0d", samples_checked, err_count);
            if (err_count == 0 && samples_checked > 0)
                $display("DONE - PASS");
            else
                $display("DONE - FAIL");
            $finish;
        end
    endtask
    initial begin
        #2000000;
        err_count = err_count + 1;
        results;
    end
    initial begin
        for (k = 0; k < 32; k = k + 1) mdl[k] = 8'h00;
        for (k = 0; k < 4; k = k + 1) begin
            mdl[7 + 6 * k] = 8'h02;
            mdl[12 + 6 * k] = 8'hb5;
        end
        repeat (2) @(posedge mclk);
        resetn <= 1'b1;
        for (k = 0; k < 32; k = k + 1) rd(k[4:0]);
        $display("reset values done");
        for (k = 0; k < 6; k = k + 1) begin
            seed = lfsr(seed);
            r = (k == 0) ? 8'h02 : (k == 1) ? 8'h3f : (k == 2) ? 8'h00
              : (k == 3) ? 8'h40 : {2'b00, seed[5:0] | 6'h02};
            wr(5'h07, r);
            idle(140);
            eff = r[6] ? 1 : (r[5:0] < 6'h02) ? 2 : r[5:0];
            n = 0;
            repeat (4 * eff) begin
                n = n + iq_ready;
                idle(1);
            end
            check(n, 4, 0);
        end
        $display("ratio cadence done");
        wr(5'h06, 8'h03);
        wr(5'h07, 8'h40);
        out_case(14'h1000, 8'h80, 14'h0ffe, 4);
        out_case(14'h1000, 8'h00, 14'h0000, 0);
        out_case(14'h0800, 8'hb5, 14'h0b4e, 8);
        out_case(14'h1fff, 8'hff, 14'h1fff, 0);
        out_case(14'h2000, 8'hff, 14'h2000, 0);
        @(posedge mclk);
        hold_off <= 1'b1;
        out_case(14'h1000, 8'h80, 14'h0000, 0);
        @(posedge mclk);
        hold_off <= 1'b0;
        wr(5'h06, 8'h01);
        out_case(14'h1000, 8'h80, 14'h0afe, 4);
        wr(5'h06, 8'h03);
        wr(5'h07, 8'h04);
        out_case(14'h1000, 8'h80, 14'h0ffe, 8);
        wr(5'h06, 8'h02);
        out_case(14'h1000, 8'h80, 14'h0ffe, 8);
        $display("output scaling done");
        wr(5'h06, 8'h03);
        wr(5'h07, 8'h40);
        wr(5'h0b, 8'h40);
        idle(20);
        for (k = 0; k < 4; k = k + 1) begin
            d[k] = dac_data;
            idle(1);
        end
        check(d[0] + d[2], 14'h0000, 2);
        eff = (d[0] < 0) ? -d[0] : d[0];
        n = (d[1] < 0) ? -d[1] : d[1];
        check((eff > n) ? eff : n, 14'h0ffe, 8);
        @(posedge mclk);
        level_i <= 14'h0000;
        level_q <= 14'h1000;
        nz = 0;
        // freezing on odd and even step counts lands one pass off the axis
        for (k = 0; k < 3; k = k + 1) begin
            wr(5'h0b, 8'h40);
            idle(k % 2);
            wr(5'h0b, 8'h00);
            idle(40);
            d[0] = dac_data;
            wr(5'h07, 8'hc0);
            idle(40);
            check(d[0] + dac_data, 14'h0000, 2);
            nz = nz + (d[0] != 0);
            wr(5'h07, 8'h40);
        end
        check(nz > 0, 1, 0);
        $display("carrier and inversion done");
        for (k = 8; k < 12; k = k + 1) begin
            seed = lfsr(seed);
            wr(k[4:0], seed[7:0]);
        end
        for (k = 8; k < 12; k = k + 1) rd(k[4:0]);
        $display("frequency word bytes done");
        results;
    end
endmodule
